// File: bench/tb_top.sv
// Self-checking bench for receive error priority and routing classification
`default_nettype none
module tb_top
   import tep_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int NP = 0, VEN = 1, UPP = 2, ULT = 3, OVF = 4, ECR = 5, MAL = 6, ACS = 7, MC = 8;
   localparam int POI = 9, INT = 10, HUP = 11, HDN = 12, RSF = 13, TUP = 14, VGA = 15;
   localparam int NOR = 16, CTH = 17, CCU = 18, CDE = 19, CCD = 20, CDZ = 21, DMI = 22;
   localparam int TSW = 23, CIN = 24;
   localparam logic [24:0] MU = (25'h1 << UPP) | (25'h1 << HUP) | (25'h1 << HDN);
   localparam logic [24:0] MD = 25'h1 << HDN;
   localparam logic [24:0] CU = (25'h1 << UPP) | (25'h1 << CTH) | (25'h1 << CDE) | (25'h1 << CDZ);
   // Outcome bits: fwd_up, internal, consumed, ur, unexpected cpl, ur cpl, abort cpl
   localparam logic [6:0] X0 = 7'h00, X_CONS = 7'h10, X_UR = 7'h18, X_URC = 7'h1A;
   localparam logic [6:0] X_UC = 7'h14, X_FWU = 7'h40;
   localparam logic [5:0] CALL = 6'h0F, CUF = 6'h2F, CARI = 6'h1F;
   logic hclk, hresetn, hsel, hwrite, go, tlp_valid;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, hresp;
   logic [2:0] hsize, res_log_code;
   logic hreadyout, res_valid, res_log_internal, res_drop, res_nullify, res_forward;
   logic res_fwd_upstream, res_ur, res_unexp_cpl, res_gen_ur_cpl, res_gen_ca_cpl;
   logic [27:0] pkt, tlp_bus;
   int n_mismatch = 0, tests_run = 0, cyc = 0, idx = 0;
   int rf[3] = '{RSF, NOR, DMI};

   tep_link_model tep_link_model_inst (.hclk(hclk), .hresetn(hresetn), .go(go), .pkt(pkt),
      .tlp_valid(tlp_valid), .tlp_bus(tlp_bus));
   tep_route_err #(.DATA_W(32)) tep_route_err_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .tlp_valid(tlp_valid), .tlp_kind(tlp_bus[2:0]),
      .tlp_non_posted(tlp_bus[3]), .tlp_vendor(tlp_bus[4]), .rx_on_upstream(tlp_bus[5]),
      .ultimate_rx(tlp_bus[6]), .err_overflow(tlp_bus[7]), .err_ecrc(tlp_bus[8]),
      .err_malformed(tlp_bus[9]), .err_acs_block(tlp_bus[10]), .err_mcast_block(tlp_bus[11]),
      .err_poisoned(tlp_bus[12]), .err_internal(tlp_bus[13]), .hit_up_window(tlp_bus[14]),
      .hit_dn_window(tlp_bus[15]), .route_self(tlp_bus[16]), .target_upstream(tlp_bus[17]),
      .vga_route(tlp_bus[18]), .no_route(tlp_bus[19]), .cfg_thru_upstream(tlp_bus[20]),
      .cfg_conv_upstream(tlp_bus[21]), .cfg_dev_enabled(tlp_bus[22]),
      .cfg_conv_dnstream(tlp_bus[23]), .cfg_dev_zero(tlp_bus[24]), .dev_missing(tlp_bus[25]),
      .target_switch_port(tlp_bus[26]), .cpl_internal(tlp_bus[27]), .res_valid(res_valid),
      .res_log_code(res_log_code), .res_log_internal(res_log_internal), .res_drop(res_drop),
      .res_nullify(res_nullify), .res_forward(res_forward), .res_fwd_upstream(res_fwd_upstream),
      .res_ur(res_ur), .res_unexp_cpl(res_unexp_cpl), .res_gen_ur_cpl(res_gen_ur_cpl),
      .res_gen_ca_cpl(res_gen_ca_cpl));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   function automatic logic [24:0] b(input int i);
      return 25'h1 << i;
   endfunction : b

   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e || hresp !== TEP_HRESP_OKAY) begin
         n_mismatch++;
         $display("unexpected register %h expected %h seen %h", a, e, g);
      end
   endtask : chk_reg

   task automatic chk_res(input logic [12:0] e, input logic [12:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected result %0d expected %h seen %h", idx, e, g);
      end
   endtask : chk_res

   // Bounded wait for the single slave's ready at a rising edge
   task automatic rdy(inout int n);
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 20) begin
         @(posedge hclk);
         n++;
      end
   endtask : rdy

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= TEP_HTRANS_NONSEQ;
      rdy(n);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy(n);
      d = hrdata;
      if (n >= 20) n_mismatch++;
   endtask : ahb

   task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0, rd);
      chk_reg(a, e, rd);
   endtask : reg_chk

   // One TLP under a given control setting; results stand one cycle after it is taken
   task automatic run(input tep_kind_t k, input logic [24:0] f, input logic [5:0] c,
         input logic [9:0] e);
      logic nul_e;
      // Malformed nullifies unless overflow or an ultimate-receiver ECRC drop came first
      nul_e = f[MAL] && !f[OVF] && !(f[ECR] && f[ULT]);
      ahb(1'b1, TEP_CTRL_ADDR, {26'h0, c}, rd);
      go <= 1'b1;
      pkt <= {f, k};
      @(posedge hclk);
      go <= 1'b0;
      @(posedge hclk);
      #1;
      idx++;
      chk_res({1'b1, e, !e[4], nul_e}, {res_valid, res_log_code, res_fwd_upstream,
         res_log_internal, res_drop | res_nullify, res_ur, res_unexp_cpl, res_gen_ur_cpl,
         res_gen_ca_cpl, res_forward, res_nullify});
      @(posedge hclk);
   endtask : run

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         results();
      end
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      go = 1'b0;
      pkt = 28'h0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      reg_chk(TEP_CTRL_ADDR, 32'h0);
      reg_chk(TEP_STAT_ADDR, 32'h0);
      reg_chk(TEP_LAST_ADDR, 32'h0);
      ahb(1'b1, TEP_CTRL_ADDR, 32'hFFFFFFFF, rd);
      reg_chk(TEP_CTRL_ADDR, 32'h3F);
      ahb(1'b1, TEP_LAST_ADDR, 32'h7, rd);
      ahb(1'b1, 8'h0C, 32'hFFFFFFFF, rd);
      reg_chk(TEP_LAST_ADDR, 32'h0);
      reg_chk(8'h0C, 32'h0);
      $display("test registers done");
      run(TEP_K_MEM, MU, CALL, {TEP_E_NONE, X0});
      run(TEP_K_MEM, MU | b(POI), CALL, {TEP_E_POIS, X0});
      reg_chk(TEP_STAT_ADDR, 32'h1);
      ahb(1'b1, TEP_STAT_ADDR, 32'h1, rd);
      reg_chk(TEP_LAST_ADDR, 32'h1);
      run(TEP_K_MEM, MU | b(OVF) | b(ECR) | b(MAL) | b(POI), CALL, {TEP_E_OVF, X_CONS});
      reg_chk(TEP_STAT_ADDR, 32'h1);
      ahb(1'b1, TEP_STAT_ADDR, 32'h1, rd);
      run(TEP_K_MEM, MU | b(ECR), CALL, {TEP_E_ECRC, X0});
      run(TEP_K_MEM, MU | b(ECR) | b(ULT), CALL, {TEP_E_ECRC, X_CONS});
      run(TEP_K_MEM, MU | b(ECR) | b(MAL), CALL, {TEP_E_ECRC, X_CONS});
      run(TEP_K_MEM, MD | b(NP) | b(ACS), CALL, {TEP_E_ACS, 7'h11});
      run(TEP_K_MEM, MD | b(NP) | b(ACS) | b(ECR), CALL, {TEP_E_ECRC, X_CONS});
      run(TEP_K_MEM, MD | b(MC), CALL, {TEP_E_MC, X_CONS});
      run(TEP_K_MEM, MD | b(MC) | b(ECR), CALL, {TEP_E_ECRC, X_CONS});
      run(TEP_K_MEM, MD | b(MAL) | b(ACS) | b(NP) | b(POI), CALL, {TEP_E_MAL, X_CONS});
      reg_chk(TEP_STAT_ADDR, 32'h2);
      reg_chk(TEP_LAST_ADDR, 32'h5);
      run(TEP_K_MEM, MD | b(NP) | b(ECR), 6'h0B, {TEP_E_ECRC, X_UR});
      run(TEP_K_MEM, MD | b(NP), 6'h0B, {TEP_E_UR, X_URC});
      run(TEP_K_MEM, MU | b(INT) | b(POI), CALL, {TEP_E_POIS, 7'h20});
      run(TEP_K_MEM, MU | b(INT) | b(MAL), CALL, {TEP_E_MAL, 7'h30});
      $display("test priority done");
      run(TEP_K_MEM, b(UPP) | b(HUP), CALL, {TEP_E_UR, X_UR});
      run(TEP_K_MEM, b(UPP) | b(HUP) | b(NP), CALL, {TEP_E_UR, X_URC});
      run(TEP_K_MEM, b(HUP), CALL, {TEP_E_UR, X_UR});
      run(TEP_K_MEM, b(RSF), CALL, {TEP_E_UR, X_UR});
      run(TEP_K_MEM, b(RSF), CUF, {TEP_E_NONE, X_FWU});
      run(TEP_K_MEM, MU, 6'h0E, {TEP_E_UR, X_UR});
      run(TEP_K_IO, MU, 6'h0D, {TEP_E_UR, X_UR});
      run(TEP_K_MEM, b(TUP), 6'h07, {TEP_E_UR, X_UR});
      run(TEP_K_MEM, MD | b(VGA), CALL, {TEP_E_UR, X_UR});
      run(TEP_K_CFG0, 25'h0, CALL, {TEP_E_UR, X_UR});
      run(TEP_K_CFG1, 25'h0, CALL, {TEP_E_UR, X_UR});
      run(TEP_K_CFG1, CU, CALL, {TEP_E_NONE, X0});
      run(TEP_K_CFG1, CU & ~b(CTH), CALL, {TEP_E_UR, X_UR});
      run(TEP_K_CFG1, (CU | b(CCU)) & ~b(CDE), CALL, {TEP_E_UR, X_UR});
      run(TEP_K_CFG1, (CU | b(CCD)) & ~b(CDZ), CALL, {TEP_E_UR, X_UR});
      run(TEP_K_CFG1, (CU | b(CCD)) & ~b(CDZ), CARI, {TEP_E_NONE, X0});
      run(TEP_K_CPL, b(RSF), CALL, {TEP_E_NONE, X_CONS});
      run(TEP_K_CPL, b(RSF), CUF, {TEP_E_NONE, X_FWU});
      run(TEP_K_CPL, b(NOR), CALL, {TEP_E_NONE, X_CONS});
      run(TEP_K_CPL, b(CIN), CALL, {TEP_E_UR, X_UC});
      foreach (rf[i]) run(TEP_K_MSGID, b(rf[i]), CALL, {TEP_E_UR, X_UR});
      run(TEP_K_MSGT1, b(TSW), CALL, {TEP_E_UR, X_UR});
      run(TEP_K_MSGT1, b(UPP), CALL, {TEP_E_UR, X_UR});
      run(TEP_K_MSGT1, b(VEN) | b(TSW), CALL, {TEP_E_NONE, X_CONS});
      $display("test routing done");
      results();
   end
endmodule : tb_top
`default_nettype wire

// File: bench/tep_link_model.sv
// Behavioural link-side source of received TLPs with their error and decode flags
`default_nettype none
module tep_link_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Request from the bench
   input wire logic go,
   input wire logic [27:0] pkt,
   // Toward the block
   output logic tlp_valid,
   output logic [27:0] tlp_bus
);
   timeunit 1ns;
   timeprecision 1ns;
   // Between TLPs the lines toggle, so a stale flag can never pass for a live one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tlp_valid <= 1'b0;
         tlp_bus <= 28'h5555555;
      end else begin
         tlp_valid <= go;
         tlp_bus <= go ? pkt : ~tlp_bus;
      end
   end
endmodule : tep_link_model
`default_nettype wire

// File: inc/tep_pkg.sv
// Shared constants for the receive-side error priority and routing block
`default_nettype none
package tep_pkg;
   // Register byte addresses
   localparam logic [7:0] TEP_CTRL_ADDR = 8'h00;
   localparam logic [7:0] TEP_STAT_ADDR = 8'h04;
   localparam logic [7:0] TEP_LAST_ADDR = 8'h08;
   localparam int TEP_ADDR_LSB = 2;
   localparam int TEP_ADDR_MSB = 7;
   // Control field positions
   localparam int TEP_C_MEM = 0;
   localparam int TEP_C_IO = 1;
   localparam int TEP_C_BME = 2;
   localparam int TEP_C_UPBME = 3;
   localparam int TEP_C_ARI = 4;
   localparam int TEP_C_ACSUF = 5;
   localparam int TEP_CTRL_W = 6;
   localparam logic [TEP_CTRL_W-1:0] TEP_CTRL_RST = 6'h00;
   // Status field positions (write one to clear)
   localparam int TEP_S_PRI = 0;
   localparam int TEP_S_SEC = 1;
   // Logged error codes; value is the rank, unexpected completion shares 2
   localparam int TEP_CODE_W = 3;
   localparam logic [2:0] TEP_E_NONE = 3'h0;
   localparam logic [2:0] TEP_E_POIS = 3'h1;
   localparam logic [2:0] TEP_E_UR = 3'h2;
   localparam logic [2:0] TEP_E_MC = 3'h3;
   localparam logic [2:0] TEP_E_ACS = 3'h4;
   localparam logic [2:0] TEP_E_MAL = 3'h5;
   localparam logic [2:0] TEP_E_ECRC = 3'h6;
   localparam logic [2:0] TEP_E_OVF = 3'h7;
   // TLP classes
   typedef enum logic [2:0] {
      TEP_K_MEM, TEP_K_IO, TEP_K_CFG0, TEP_K_CFG1, TEP_K_CPL, TEP_K_MSGID, TEP_K_MSGT1
   } tep_kind_t;
   localparam logic [1:0] TEP_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] TEP_HRESP_OKAY = 2'h0;
endpackage : tep_pkg
`default_nettype wire

// File: rtl/tep_route_err.sv
// Receive TLP error arbitration, routing error classification and AHB registers
`default_nettype none
module tep_route_err
   import tep_pkg::*;
#(
   parameter int DATA_W = 32
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [DATA_W-1:0] hwdata,
   input wire logic hready,
   output logic [DATA_W-1:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   // Received TLP, one cycle per TLP
   input wire logic tlp_valid,
   input wire logic [2:0] tlp_kind,
   input wire logic tlp_non_posted,
   input wire logic tlp_vendor,
   input wire logic rx_on_upstream,
   input wire logic ultimate_rx,
   // Detected errors
   input wire logic err_overflow,
   input wire logic err_ecrc,
   input wire logic err_malformed,
   input wire logic err_acs_block,
   input wire logic err_mcast_block,
   input wire logic err_poisoned,
   input wire logic err_internal,
   // Route decode
   input wire logic hit_up_window,
   input wire logic hit_dn_window,
   input wire logic route_self,
   input wire logic target_upstream,
   input wire logic vga_route,
   input wire logic no_route,
   input wire logic cfg_thru_upstream,
   input wire logic cfg_conv_upstream,
   input wire logic cfg_dev_enabled,
   input wire logic cfg_conv_dnstream,
   input wire logic cfg_dev_zero,
   input wire logic dev_missing,
   input wire logic target_switch_port,
   input wire logic cpl_internal,
   // Result, one cycle after the TLP
   output logic res_valid,
   output logic [TEP_CODE_W-1:0] res_log_code,
   output logic res_log_internal,
   output logic res_drop,
   output logic res_nullify,
   output logic res_forward,
   output logic res_fwd_upstream,
   output logic res_ur,
   output logic res_unexp_cpl,
   output logic res_gen_ur_cpl,
   output logic res_gen_ca_cpl
);

   if (DATA_W != 32) begin : g_width_check
      $error("DATA_W must be 32");
   end

   function automatic logic [TEP_ADDR_MSB-TEP_ADDR_LSB:0] word_of(input logic [31:0] a);
      word_of = a[TEP_ADDR_MSB:TEP_ADDR_LSB];
   endfunction : word_of

   logic [TEP_CTRL_W-1:0] ctrl_ff;
   logic stat_pri_ff;
   logic stat_sec_ff;
   logic [TEP_CODE_W-1:0] last_ff;
   logic wr_pend_ff;
   logic [31:0] wr_addr_ff;
   logic [DATA_W-1:0] hrdata_ff;
   logic addr_ok;
   logic [DATA_W-1:0] nxt_rdata;

   logic mem_en, io_en, bus_master_enable, up_bme, ari, acs_uf;
   assign mem_en = ctrl_ff[TEP_C_MEM];
   assign io_en = ctrl_ff[TEP_C_IO];
   assign bus_master_enable = ctrl_ff[TEP_C_BME];
   assign up_bme = ctrl_ff[TEP_C_UPBME];
   assign ari = ctrl_ff[TEP_C_ARI];
   assign acs_uf = ctrl_ff[TEP_C_ACSUF];

   // Bus: zero wait states, so the read word is fetched in the address phase
   assign addr_ok = hsel && hready && (htrans == TEP_HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 32'h0000_0000;
      end else begin
         wr_pend_ff <= addr_ok && hwrite;
         wr_addr_ff <= haddr;
      end
   end

   always_comb begin
      nxt_rdata = '0;
      if (word_of(haddr) == word_of({24'h000000, TEP_CTRL_ADDR}))
         nxt_rdata[TEP_CTRL_W-1:0] = ctrl_ff;
      else if (word_of(haddr) == word_of({24'h000000, TEP_STAT_ADDR})) begin
         nxt_rdata[TEP_S_PRI] = stat_pri_ff;
         nxt_rdata[TEP_S_SEC] = stat_sec_ff;
      end else if (word_of(haddr) == word_of({24'h000000, TEP_LAST_ADDR}))
         nxt_rdata[TEP_CODE_W-1:0] = last_ff;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata_ff <= '0;
      else if (addr_ok && !hwrite)
         hrdata_ff <= nxt_rdata;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         ctrl_ff <= TEP_CTRL_RST;
      else if (wr_pend_ff && word_of(wr_addr_ff) == word_of({24'h000000, TEP_CTRL_ADDR}))
         ctrl_ff <= hwdata[TEP_CTRL_W-1:0];
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = TEP_HRESP_OKAY;

   // Parity seen: a poisoned arrival in the clearing cycle still sets the bit
   logic stat_clr;
   logic pois_pri, pois_sec;
   assign stat_clr = wr_pend_ff && word_of(wr_addr_ff) == word_of({24'h000000, TEP_STAT_ADDR});
   assign pois_pri = tlp_valid && err_poisoned && rx_on_upstream;
   assign pois_sec = tlp_valid && err_poisoned && !rx_on_upstream;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_pri_ff <= 1'b0;
         stat_sec_ff <= 1'b0;
      end else begin
         stat_pri_ff <= pois_pri || (stat_pri_ff && !(stat_clr && hwdata[TEP_S_PRI]));
         stat_sec_ff <= pois_sec || (stat_sec_ff && !(stat_clr && hwdata[TEP_S_SEC]));
      end
   end

   // Routing checks
   logic is_mem, is_io, is_addr, is_cfg, is_cpl;
   logic ur_addr, ur_cfg, ur_msg, ur_c, uc_c, silent_c, fwd_up_c;
   assign is_mem = tlp_kind == TEP_K_MEM;
   assign is_io = tlp_kind == TEP_K_IO;
   assign is_addr = is_mem || is_io;
   assign is_cfg = (tlp_kind == TEP_K_CFG0) || (tlp_kind == TEP_K_CFG1);
   assign is_cpl = tlp_kind == TEP_K_CPL;

   always_comb begin
      ur_addr = 1'b0;
      ur_cfg = 1'b0;
      ur_msg = 1'b0;
      uc_c = 1'b0;
      silent_c = 1'b0;
      fwd_up_c = 1'b0;
      if (is_addr) begin
         if (rx_on_upstream && hit_up_window && !hit_dn_window)
            ur_addr = 1'b1;
         if (!rx_on_upstream && !hit_dn_window && hit_up_window)
            ur_addr = 1'b1;
         if (!rx_on_upstream && route_self)
            ur_addr = ur_addr || !acs_uf;
         if (rx_on_upstream && ((is_mem && !mem_en) || (is_io && !io_en)))
            ur_addr = 1'b1;
         if (!rx_on_upstream && (!bus_master_enable || (target_upstream && !up_bme) || vga_route))
            ur_addr = 1'b1;
         fwd_up_c = !rx_on_upstream && route_self && acs_uf;
      end
      if (is_cfg) begin
         if (!rx_on_upstream)
            ur_cfg = 1'b1;
         if (tlp_kind == TEP_K_CFG1) begin
            if (!cfg_thru_upstream || (cfg_conv_upstream && !cfg_dev_enabled))
               ur_cfg = 1'b1;
            if (cfg_conv_dnstream && !cfg_dev_zero && !ari)
               ur_cfg = 1'b1;
         end
      end
      if (is_cpl) begin
         if (route_self)
            silent_c = !acs_uf;
         fwd_up_c = route_self && acs_uf;
         if (no_route)
            silent_c = 1'b1;
         if (cpl_internal)
            uc_c = 1'b1;
      end
      if (tlp_kind == TEP_K_MSGID) begin
         if ((route_self && !acs_uf) || no_route || dev_missing)
            ur_msg = 1'b1;
         fwd_up_c = route_self && acs_uf;
      end
      if (tlp_kind == TEP_K_MSGT1) begin
         if (tlp_vendor)
            silent_c = 1'b1;
         else if (target_switch_port || rx_on_upstream)
            ur_msg = 1'b1;
      end
   end
   assign ur_c = ur_addr || ur_cfg || ur_msg;

   // Arbitration: logging follows rank, actions continue until the TLP is gone
   logic [TEP_CODE_W-1:0] nxt_code;
   logic nxt_drop, nxt_null, nxt_ur, nxt_uc, nxt_urcpl, nxt_cacpl, ecrc_seen;

   always_comb begin
      nxt_code = TEP_E_NONE;
      nxt_drop = 1'b0;
      nxt_null = 1'b0;
      nxt_ur = 1'b0;
      nxt_uc = 1'b0;
      nxt_urcpl = 1'b0;
      nxt_cacpl = 1'b0;
      ecrc_seen = 1'b0;
      if (err_overflow) begin
         nxt_code = TEP_E_OVF;
         nxt_drop = 1'b1;
      end else begin
         if (err_ecrc) begin
            ecrc_seen = 1'b1;
            nxt_code = TEP_E_ECRC;
            nxt_drop = ultimate_rx;
         end
         if (!nxt_drop) begin
            if (err_malformed) begin
               nxt_null = 1'b1;
               nxt_drop = 1'b1;
               if (!ecrc_seen)
                  nxt_code = TEP_E_MAL;
            end else if (err_acs_block) begin
               nxt_drop = 1'b1;
               if (!ecrc_seen) begin
                  nxt_code = TEP_E_ACS;
                  nxt_cacpl = tlp_non_posted;
               end
            end else if (err_mcast_block) begin
               nxt_drop = 1'b1;
               if (!ecrc_seen)
                  nxt_code = TEP_E_MC;
            end else if (ur_c) begin
               nxt_ur = 1'b1;
               nxt_drop = 1'b1;
               if (!ecrc_seen) begin
                  nxt_code = TEP_E_UR;
                  nxt_urcpl = tlp_non_posted;
               end
            end else if (uc_c) begin
               nxt_uc = 1'b1;
               nxt_drop = 1'b1;
               if (!ecrc_seen)
                  nxt_code = TEP_E_UR;
            end else if (silent_c) begin
               nxt_drop = 1'b1;
            end else if (err_poisoned && !ecrc_seen) begin
               nxt_code = TEP_E_POIS;
            end
         end
      end
   end

   // Result register; every output comes straight from a flop
   logic res_valid_ff, res_int_ff, res_drop_ff, res_null_ff, res_fwd_ff, res_fup_ff;
   logic res_ur_ff, res_uc_ff, res_urcpl_ff, res_cacpl_ff;
   logic [TEP_CODE_W-1:0] res_code_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         res_valid_ff <= 1'b0;
         res_code_ff <= TEP_E_NONE;
         res_int_ff <= 1'b0;
         res_drop_ff <= 1'b0;
         res_null_ff <= 1'b0;
         res_fwd_ff <= 1'b0;
         res_fup_ff <= 1'b0;
         res_ur_ff <= 1'b0;
         res_uc_ff <= 1'b0;
         res_urcpl_ff <= 1'b0;
         res_cacpl_ff <= 1'b0;
      end else begin
         res_valid_ff <= tlp_valid;
         res_code_ff <= tlp_valid ? nxt_code : TEP_E_NONE;
         res_int_ff <= tlp_valid && err_internal;
         res_drop_ff <= tlp_valid && nxt_drop;
         res_null_ff <= tlp_valid && nxt_null;
         res_fwd_ff <= tlp_valid && !nxt_drop;
         res_fup_ff <= tlp_valid && !nxt_drop && fwd_up_c;
         res_ur_ff <= tlp_valid && nxt_ur;
         res_uc_ff <= tlp_valid && nxt_uc;
         res_urcpl_ff <= tlp_valid && nxt_urcpl;
         res_cacpl_ff <= tlp_valid && nxt_cacpl;
      end
   end

   // Last logged code, readable by software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         last_ff <= TEP_E_NONE;
      else if (tlp_valid && nxt_code != TEP_E_NONE)
         last_ff <= nxt_code;
   end

   assign res_valid = res_valid_ff;
   assign res_log_code = res_code_ff;
   assign res_log_internal = res_int_ff;
   assign res_drop = res_drop_ff;
   assign res_nullify = res_null_ff;
   assign res_forward = res_fwd_ff;
   assign res_fwd_upstream = res_fup_ff;
   assign res_ur = res_ur_ff;
   assign res_unexp_cpl = res_uc_ff;
   assign res_gen_ur_cpl = res_urcpl_ff;
   assign res_gen_ca_cpl = res_cacpl_ff;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_ovf_top: assert property (tlp_valid && err_overflow
      |=> res_log_code == TEP_E_OVF && res_drop)
      else $error("overflow not logged first");
   chk_ecrc_only: assert property (tlp_valid && !err_overflow && err_ecrc
      |=> res_log_code == TEP_E_ECRC)
      else $error("ECRC not the logged error");
   chk_internal_log: assert property (tlp_valid && err_internal |=> res_log_internal)
      else $error("internal error not logged");
   chk_parity_seen: assert property (tlp_valid && err_poisoned && rx_on_upstream
      |=> stat_pri_ff)
      else $error("primary parity seen not set");
   chk_mal_drop: assert property (tlp_valid && !err_overflow && !err_ecrc
      && err_malformed |=> res_drop && res_nullify && res_log_code == TEP_E_MAL)
      else $error("malformed TLP kept");
   chk_ecrc_ultimate: assert property (tlp_valid && !err_overflow && err_ecrc
      && ultimate_rx |=> res_drop && !res_ur && !res_nullify)
      else $error("ultimate ECRC not dropped");
   chk_ecrc_quiet: assert property (res_valid && res_log_code == TEP_E_ECRC
      |-> !res_gen_ur_cpl && !res_gen_ca_cpl)
      else $error("completion after ECRC");
   chk_poison_clean: assert property (res_log_code == TEP_E_POIS
      |-> res_forward && !res_ur)
      else $error("poison logged on failed TLP");
   chk_mem_enable: assert property (tlp_valid && is_mem && rx_on_upstream && !mem_en
      && !err_overflow && !err_ecrc && !err_malformed && !err_acs_block && !err_mcast_block
      |=> res_ur && res_log_code == TEP_E_UR)
      else $error("disabled memory access not UR");

   cov_ecrc_ur: cover property (tlp_valid && err_ecrc && !ultimate_rx && ur_c ##1 res_ur);
   cov_poison: cover property (res_valid && res_log_code == TEP_E_POIS);
   cov_fwd_up: cover property (res_fwd_upstream);

endmodule : tep_route_err
`default_nettype wire
